// file: rtl/sirr_pkg.sv
// Package of constants and carrier types for the status and information read responder.
package sirr_pkg;

	// ==========================================================================
	// Query op-codes
	localparam logic [7:0] OP_SOURCE   = 8'hb6;
	localparam logic [7:0] OP_DISPLAY  = 8'hb8;
	localparam logic [7:0] OP_SYSINFO  = 8'hba;
	localparam logic [7:0] OP_FLASH    = 8'hbb;
	localparam logic [7:0] OP_SHORT    = 8'hc0;

	// ==========================================================================
	// Response lengths in bytes
	localparam logic [3:0] LEN_SOURCE  = 4'hf;
	localparam logic [3:0] LEN_DISPLAY = 4'hc;
	localparam logic [3:0] LEN_SYSINFO = 4'h2;
	localparam logic [3:0] LEN_FLASH   = 4'h3;
	localparam logic [3:0] LEN_SHORT   = 4'h4;
	localparam int         RESP_BYTES  = 15;

	// ==========================================================================
	// Source type codes
	localparam logic [7:0] SRC_VIDEO   = 8'h00;
	localparam logic [7:0] SRC_PATTERN = 8'h01;
	localparam logic [7:0] SRC_SPLASH  = 8'h02;
	localparam logic [7:0] SRC_STANDBY = 8'h03;

	// ==========================================================================
	// Video format, pattern, colour, reset cause and product codes
	localparam logic [7:0] FMT_SERIAL    = 8'h00;
	localparam logic [7:0] FMT_PARALLEL  = 8'h40;
	localparam logic [3:0] PAT_LAST      = 4'h8;
	localparam logic [3:0] COLOR_LAST    = 4'h7;
	localparam logic [2:0] SPLASH_LAST   = 3'h7;
	localparam logic [7:0] RST_POWERUP   = 8'h00;
	localparam logic [7:0] RST_PIN       = 8'h01;
	localparam logic [7:0] RST_OVERTEMP  = 8'h04;
	localparam logic [7:0] RST_SW_CYCLE  = 8'h05;
	localparam logic [7:0] RST_HOST      = 8'h07;
	localparam logic [7:0] RST_CTRL_ONLY = 8'h08;
	localparam logic [7:0] PROD_HUD      = 8'h00;
	localparam logic [7:0] PROD_LIGHT    = 8'h01;
	localparam logic [1:0] APP_BOOT      = 2'h0;
	localparam logic [1:0] APP_STANDBY   = 2'h1;
	localparam logic [1:0] APP_DISPLAY   = 2'h2;

	// ==========================================================================
	// Flash read op-codes, one per capability bit
	localparam logic [7:0] FL_FAST   = 8'h0b;
	localparam logic [7:0] FL_DUAL_O = 8'h3b;
	localparam logic [7:0] FL_DUAL_IO = 8'hbb;
	localparam logic [7:0] FL_QUAD_O = 8'h6b;
	localparam logic [7:0] FL_QUAD_IO = 8'heb;

	// ==========================================================================
	// Register offsets of the plain register port
	localparam logic [4:0] REG_SRC_TYPE   = 5'h00;
	localparam logic [4:0] REG_VSYNC      = 5'h01;
	localparam logic [4:0] REG_VID_FMT    = 5'h02;
	localparam logic [4:0] REG_POL        = 5'h03;
	localparam logic [4:0] REG_PCLK       = 5'h04;
	localparam logic [4:0] REG_TOT_PIX    = 5'h05;
	localparam logic [4:0] REG_TOT_LINES  = 5'h06;
	localparam logic [4:0] REG_ACT_PIX    = 5'h07;
	localparam logic [4:0] REG_ACT_LINES  = 5'h08;
	localparam logic [4:0] REG_PATTERN    = 5'h09;
	localparam logic [4:0] REG_SPLASH     = 5'h0a;
	localparam logic [4:0] REG_DISPLAY    = 5'h0b;
	localparam logic [4:0] REG_INDICES    = 5'h0c;
	localparam logic [4:0] REG_SYSINFO    = 5'h0d;
	localparam logic [4:0] REG_FLASH      = 5'h0e;
	localparam logic [4:0] REG_STATUS     = 5'h0f;
	localparam logic [4:0] REG_ERROR      = 5'h10;
	localparam logic [4:0] REG_LIVE       = 5'h11;

	// ==========================================================================
	// Field positions
	localparam int POL_DVALID = 3;
	localparam int POL_EDGE   = 2;
	localparam int POL_LINE   = 1;
	localparam int POL_FRAME  = 0;
	localparam int ST_SHUT    = 5;
	localparam int ST_AVAIL   = 3;
	localparam int ST_BUSY    = 2;
	localparam int ST_REQ     = 1;
	localparam int ST_INIT    = 0;
	localparam int ERR_COMM   = 12;

	// ==========================================================================
	// Carrier types
	typedef struct packed {
		logic [7:0] op;
		logic [7:0] tag;
	} sirr_query_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] idx;
		logic [7:0] data;
		logic       last;
	} sirr_byte_t;

endpackage : sirr_pkg

// file: rtl/sirr_sync.sv
// Two-flop synchroniser for a group of levels from outside the clock domain.
`timescale 1ns/1ns
module sirr_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         reset,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_reg;

	// The first stage is read only by the second stage.
	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule : sirr_sync

// file: rtl/sirr_top.sv
// Status and information read responder: builds query answers and streams them out.
// Function
// - Source query always answers fifteen bytes.
// - Byte one encodes source type.
// - Bytes two, three: frame rate, eighth hertz.
// - Video format byte: serial or parallel.
// - Data-valid polarity and sampling edge bits.
// - Line and frame sync polarity bits.
// - Pixel clock, eighth megahertz, little endian.
// - Four timing counts, little endian.
// - Byte four encodes test pattern type.
// - Foreground and background colour nibbles.
// - Unused trailing source bytes are zero.
// - Splash index zero to seven.
// - Display info: illumination, flips, indices.
// - Reset cause byte codes.
// - Product configuration byte codes.
// - Flash capability bits, upper bits zero.
// - Maximum flash clock times one hundred.
// - Flash read op-codes per capability.
// - Short status answered directly from hardware.
// - Short status application and mode bits.
// - Short status flag bit positions.
// - Communication error bit and error code.
// - Busy while receive buffer full.
// - New prefetch replaces unfetched data silently.
`timescale 1ns/1ns
module sirr_top (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 reset,
	// Register port
	input  wire logic [4:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	// Query request from the command interpreter
	input  wire sirr_pkg::sirr_query_t query,
	input  wire logic                 query_valid,
	// Live status levels from other clock domains
	input  wire logic                 rx_buffer_full,
	input  wire logic                 prefetch_pulse_lvl,
	input  wire logic                 fetch_done_lvl,
	// Response byte stream
	output sirr_pkg::sirr_byte_t      resp,
	output logic                      busy
);

	// ==========================================================================
	// Synchronised live levels
	logic [2:0] live_sync;
	logic [2:0] live_prev_reg;

	sirr_sync #(.W(3)) u_sync (
		.mclk     (mclk),
		.reset    (reset),
		.async_in ({rx_buffer_full, prefetch_pulse_lvl, fetch_done_lvl}),
		.sync_out (live_sync)
	);

	always_ff @(posedge mclk) begin
		if (reset) begin
			live_prev_reg <= '0;
		end else begin
			live_prev_reg <= live_sync;
		end
	end

	// Toggle levels mark one prefetch or one fetch per change.
	logic prefetch_evt;
	logic fetch_evt;
	assign prefetch_evt = live_sync[1] ^ live_prev_reg[1];
	assign fetch_evt    = live_sync[0] ^ live_prev_reg[0];

	// ==========================================================================
	// Software-written settings
	logic [7:0]  src_type_reg;
	logic [15:0] vsync_reg;
	logic [7:0]  vid_fmt_reg;
	logic [3:0]  pol_reg;
	logic [15:0] pclk_reg;
	logic [15:0] tot_pix_reg;
	logic [15:0] tot_lines_reg;
	logic [15:0] act_pix_reg;
	logic [15:0] act_lines_reg;
	logic [11:0] pattern_reg;
	logic [2:0]  splash_reg;
	logic [2:0]  display_reg;
	logic [31:0] indices_reg;
	logic [15:0] sysinfo_reg;
	logic [23:0] flash_reg;
	logic [7:0]  status_reg;
	logic [7:0]  tag_reg;
	logic [12:0] error_reg;
	logic        avail_reg;

	always_ff @(posedge mclk) begin
		if (reset) begin
			src_type_reg  <= sirr_pkg::SRC_STANDBY;
			vsync_reg     <= '0;
			vid_fmt_reg   <= sirr_pkg::FMT_SERIAL;
			pol_reg       <= '0;
			pclk_reg      <= '0;
			tot_pix_reg   <= '0;
			tot_lines_reg <= '0;
			act_pix_reg   <= '0;
			act_lines_reg <= '0;
			pattern_reg   <= '0;
			splash_reg    <= '0;
			display_reg   <= '0;
			indices_reg   <= '0;
			sysinfo_reg   <= {sirr_pkg::PROD_LIGHT, sirr_pkg::RST_POWERUP};
			flash_reg     <= '0;
			status_reg    <= '0;
			tag_reg       <= '0;
			error_reg     <= '0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				sirr_pkg::REG_SRC_TYPE: begin
					// Codes above standby fold to standby.
					src_type_reg <= (reg_wdata[7:0] > sirr_pkg::SRC_STANDBY) ?
						sirr_pkg::SRC_STANDBY : reg_wdata[7:0];
				end
				sirr_pkg::REG_VSYNC:     vsync_reg     <= reg_wdata[15:0];
				sirr_pkg::REG_VID_FMT: begin
					vid_fmt_reg <= reg_wdata[0] ? sirr_pkg::FMT_PARALLEL :
						sirr_pkg::FMT_SERIAL;
				end
				sirr_pkg::REG_POL:       pol_reg       <= reg_wdata[3:0];
				sirr_pkg::REG_PCLK:      pclk_reg      <= reg_wdata[15:0];
				sirr_pkg::REG_TOT_PIX:   tot_pix_reg   <= reg_wdata[15:0];
				sirr_pkg::REG_TOT_LINES: tot_lines_reg <= reg_wdata[15:0];
				sirr_pkg::REG_ACT_PIX:   act_pix_reg   <= reg_wdata[15:0];
				sirr_pkg::REG_ACT_LINES: act_lines_reg <= reg_wdata[15:0];
				sirr_pkg::REG_PATTERN:   pattern_reg   <= reg_wdata[11:0];
				sirr_pkg::REG_SPLASH:    splash_reg    <= reg_wdata[2:0];
				sirr_pkg::REG_DISPLAY:   display_reg   <= reg_wdata[2:0];
				sirr_pkg::REG_INDICES:   indices_reg   <= reg_wdata;
				sirr_pkg::REG_SYSINFO:   sysinfo_reg   <= reg_wdata[15:0];
				sirr_pkg::REG_FLASH:     flash_reg     <= {reg_wdata[23:8], 3'h0, reg_wdata[4:0]};
				sirr_pkg::REG_STATUS: begin
					status_reg <= {reg_wdata[7:6], reg_wdata[5], 5'h0};
					status_reg[sirr_pkg::ST_REQ]  <= reg_wdata[sirr_pkg::ST_REQ];
					status_reg[sirr_pkg::ST_INIT] <= reg_wdata[sirr_pkg::ST_INIT];
					tag_reg <= reg_wdata[15:8];
				end
				sirr_pkg::REG_ERROR:     error_reg     <= reg_wdata[12:0];
				default: ;
			endcase
		end
	end

	// Availability: a prefetch sets it, a fetch clears it; a new prefetch just re-sets it,
	// so older unfetched data is dropped with no error shown.
	always_ff @(posedge mclk) begin
		if (reset) begin
			avail_reg <= 1'b0;
		end else if (prefetch_evt) begin
			avail_reg <= 1'b1;
		end else if (fetch_evt) begin
			avail_reg <= 1'b0;
		end
	end

	// ==========================================================================
	// Register read-back
	always_ff @(posedge mclk) begin
		if (reset) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				sirr_pkg::REG_SRC_TYPE:  reg_rdata <= {24'h0, src_type_reg};
				sirr_pkg::REG_VSYNC:     reg_rdata <= {16'h0, vsync_reg};
				sirr_pkg::REG_VID_FMT:   reg_rdata <= {24'h0, vid_fmt_reg};
				sirr_pkg::REG_POL:       reg_rdata <= {28'h0, pol_reg};
				sirr_pkg::REG_PCLK:      reg_rdata <= {16'h0, pclk_reg};
				sirr_pkg::REG_TOT_PIX:   reg_rdata <= {16'h0, tot_pix_reg};
				sirr_pkg::REG_TOT_LINES: reg_rdata <= {16'h0, tot_lines_reg};
				sirr_pkg::REG_ACT_PIX:   reg_rdata <= {16'h0, act_pix_reg};
				sirr_pkg::REG_ACT_LINES: reg_rdata <= {16'h0, act_lines_reg};
				sirr_pkg::REG_PATTERN:   reg_rdata <= {20'h0, pattern_reg};
				sirr_pkg::REG_SPLASH:    reg_rdata <= {29'h0, splash_reg};
				sirr_pkg::REG_DISPLAY:   reg_rdata <= {29'h0, display_reg};
				sirr_pkg::REG_INDICES:   reg_rdata <= indices_reg;
				sirr_pkg::REG_SYSINFO:   reg_rdata <= {16'h0, sysinfo_reg};
				sirr_pkg::REG_FLASH:     reg_rdata <= {8'h0, flash_reg};
				sirr_pkg::REG_STATUS:    reg_rdata <= {16'h0, tag_reg, status_word()};
				sirr_pkg::REG_ERROR:     reg_rdata <= {19'h0, error_reg};
				sirr_pkg::REG_LIVE:      reg_rdata <= {29'h0, live_sync};
				default:                 reg_rdata <= '0;
			endcase
		end
	end

	// ==========================================================================
	// Response assembly
	// Byte one of short status mixes software bits with live hardware flags.
	function automatic logic [7:0] status_word();
		logic [7:0] s;
		s = status_reg;
		s[4] = 1'b0;
		s[sirr_pkg::ST_AVAIL] = avail_reg;
		s[sirr_pkg::ST_BUSY]  = live_sync[2];
		return s;
	endfunction : status_word

	localparam int RESP_IDX = sirr_pkg::RESP_BYTES;
	logic [7:0] frame [RESP_IDX];
	logic [7:0] frame_next [sirr_pkg::RESP_BYTES];
	logic [3:0] len_next;

	always_comb begin
		for (int i = 0; i < sirr_pkg::RESP_BYTES; i++) begin
			frame_next[i] = 8'h00;
		end
		len_next = sirr_pkg::LEN_SHORT;
		unique case (query.op)
			sirr_pkg::OP_SOURCE: begin
				len_next = sirr_pkg::LEN_SOURCE;
				frame_next[0] = src_type_reg;
				if (src_type_reg != sirr_pkg::SRC_STANDBY) begin
					frame_next[1] = vsync_reg[7:0];
					frame_next[2] = vsync_reg[15:8];
				end
				if (src_type_reg == sirr_pkg::SRC_VIDEO) begin
					frame_next[3]  = vid_fmt_reg;
					frame_next[4]  = {4'h0, pol_reg};
					frame_next[5]  = pclk_reg[7:0];
					frame_next[6]  = pclk_reg[15:8];
					frame_next[7]  = tot_pix_reg[7:0];
					frame_next[8]  = tot_pix_reg[15:8];
					frame_next[9]  = tot_lines_reg[7:0];
					frame_next[10] = tot_lines_reg[15:8];
					frame_next[11] = act_pix_reg[7:0];
					frame_next[12] = act_pix_reg[15:8];
					frame_next[13] = act_lines_reg[7:0];
					frame_next[14] = act_lines_reg[15:8];
				end else if (src_type_reg == sirr_pkg::SRC_PATTERN) begin
					frame_next[3] = {4'h0, pattern_reg[3:0]};
					frame_next[4] = {indices_color(pattern_reg[7:4])};
				end else if (src_type_reg == sirr_pkg::SRC_SPLASH) begin
					frame_next[3] = {5'h0, splash_reg};
				end
			end
			sirr_pkg::OP_DISPLAY: begin
				len_next = sirr_pkg::LEN_DISPLAY;
				frame_next[0]  = {7'h0, display_reg[2]};
				frame_next[1]  = {6'h0, display_reg[1:0]};
				frame_next[8]  = indices_reg[7:0];
				frame_next[9]  = indices_reg[15:8];
				frame_next[10] = indices_reg[23:16];
				frame_next[11] = indices_reg[31:24];
			end
			sirr_pkg::OP_SYSINFO: begin
				len_next = sirr_pkg::LEN_SYSINFO;
				frame_next[0] = sysinfo_reg[7:0];
				frame_next[1] = sysinfo_reg[15:8];
			end
			sirr_pkg::OP_FLASH: begin
				len_next = sirr_pkg::LEN_FLASH;
				frame_next[0] = flash_reg[7:0];
				frame_next[1] = flash_reg[15:8];
				frame_next[2] = flash_reg[23:16];
			end
			default: begin
				len_next = sirr_pkg::LEN_SHORT;
				frame_next[0] = status_word();
				frame_next[1] = tag_reg;
				frame_next[2] = error_reg[7:0];
				frame_next[3] = {3'h0, error_reg[12:8]};
			end
		endcase
	end

	// Pattern colours: foreground high nibble, background low nibble, both as written.
	function automatic logic [7:0] indices_color(input logic [3:0] fg);
		return {fg, pattern_reg[11:8]};
	endfunction : indices_color

	// ==========================================================================
	// Byte streamer
	typedef enum logic [1:0] {
		SIRR_IDLE = 2'b01,
		SIRR_SEND = 2'b10
	} sirr_state_t;

	sirr_state_t state_reg;
	logic [3:0]  idx_reg;
	logic [3:0]  len_reg;

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_reg <= SIRR_IDLE;
			idx_reg   <= '0;
			len_reg   <= '0;
			resp      <= '0;
			busy      <= 1'b0;
			for (int i = 0; i < sirr_pkg::RESP_BYTES; i++) begin
				frame[i] <= '0;
			end
		end else begin
			unique case (state_reg)
				SIRR_IDLE: begin
					resp <= '0;
					if (query_valid) begin
						frame     <= frame_next;
						len_reg   <= len_next;
						idx_reg   <= '0;
						busy      <= 1'b1;
						state_reg <= SIRR_SEND;
					end
				end
				SIRR_SEND: begin
					resp.valid <= 1'b1;
					resp.idx   <= idx_reg;
					resp.data  <= frame[idx_reg];
					resp.last  <= (idx_reg == len_reg - 4'h1);
					if (idx_reg == len_reg - 4'h1) begin
						busy      <= 1'b0;
						state_reg <= SIRR_IDLE;
					end else begin
						idx_reg <= idx_reg + 4'h1;
					end
				end
			endcase
		end
	end

	// ==========================================================================
	// Checks
	property p_src_len;
		@(posedge mclk) disable iff (reset)
		(state_reg == SIRR_IDLE && query_valid && query.op == sirr_pkg::OP_SOURCE)
			|-> ##16 (resp.valid && resp.last && resp.idx == 4'he);
	endproperty
	a_src_len: assert property (p_src_len) else $error("source answer not 15 bytes");

	property p_pad_zero;
		@(posedge mclk) disable iff (reset)
		(resp.valid && len_reg == sirr_pkg::LEN_SOURCE && idx_reg > 4'h9
			&& src_type_reg != sirr_pkg::SRC_VIDEO) |=> (resp.data == 8'h00);
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("pad byte not zero");

	property p_busy_flag;
		@(posedge mclk) disable iff (reset)
		(query_valid && state_reg == SIRR_IDLE && query.op == sirr_pkg::OP_SHORT)
			|-> ##2 (resp.idx == 4'h0 && resp.data[sirr_pkg::ST_BUSY] == $past(live_sync[2], 2));
	endproperty
	a_busy_flag: assert property (p_busy_flag) else $error("busy bit wrong");

	property p_avail;
		@(posedge mclk) disable iff (reset)
		prefetch_evt |=> avail_reg;
	endproperty
	a_avail: assert property (p_avail) else $error("prefetch lost");

	property p_flash_hi;
		@(posedge mclk) disable iff (reset)
		flash_reg[7:5] == 3'h0;
	endproperty
	a_flash_hi: assert property (p_flash_hi) else $error("flash upper bits set");

	property p_short_len;
		@(posedge mclk) disable iff (reset)
		(state_reg == SIRR_IDLE && query_valid && query.op == sirr_pkg::OP_SHORT)
			|-> ##5 (resp.last && resp.idx == 4'h3);
	endproperty
	a_short_len: assert property (p_short_len) else $error("short status length");

	property p_reserved;
		@(posedge mclk) disable iff (reset)
		(resp.valid && len_reg == sirr_pkg::LEN_SHORT && resp.idx == 4'h0) |-> !resp.data[4];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved status bit set");

	property p_src_type;
		@(posedge mclk) disable iff (reset)
		src_type_reg <= sirr_pkg::SRC_STANDBY;
	endproperty
	a_src_type: assert property (p_src_type) else $error("bad source type");

	c_source: cover property (@(posedge mclk) resp.last && len_reg == sirr_pkg::LEN_SOURCE);
	c_short:  cover property (@(posedge mclk) resp.last && len_reg == sirr_pkg::LEN_SHORT);
	c_flush:  cover property (@(posedge mclk) avail_reg && prefetch_evt);

endmodule : sirr_top

// file: sim/sirr_host_model.sv
// Host-side model that issues queries and gathers the response bytes.
`timescale 1ns/1ns
module sirr_host_model (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 reset,
	// Bench commands
	input  wire logic                 start,
	input  wire logic                 poke,
	input  wire logic [7:0]           op,
	// Design side
	input  wire sirr_pkg::sirr_byte_t resp,
	input  wire logic                 busy,
	output sirr_pkg::sirr_query_t     query,
	output logic                      query_valid,
	// Gathered answer
	output logic      [7:0]           got [0:14],
	output logic      [4:0]           n_got,
	output logic                      order_bad,
	output logic                      done
);
	logic pend;

	// ==========================================================================
	// Query issue
	// A polite request waits for the stream to end; a poke is the rude one.
	always_ff @(posedge mclk) begin
		if (reset) begin
			pend <= 1'b0;
			query_valid <= 1'b0;
			query <= '0;
		end else begin
			query_valid <= 1'b0;
			if (start) begin
				pend <= 1'b1;
			end else if (poke || (pend && !busy)) begin
				pend <= 1'b0;
				query_valid <= 1'b1;
				query <= {op, 8'h5a};
			end
		end
	end

	// ==========================================================================
	// Byte gathering
	// Bytes are kept raw; which colour nibbles matter is left to software.
	always_ff @(posedge mclk) begin
		if (reset || start) begin
			n_got <= 5'h00;
			done <= 1'b0;
			order_bad <= 1'b0;
		end else if (resp.valid) begin
			if (resp.idx < 4'hf) begin
				got[resp.idx] <= resp.data;
			end
			n_got <= n_got + 5'h01;
			if (resp.idx != n_got[3:0]) begin
				order_bad <= 1'b1;
			end
			if (resp.last) begin
				done <= 1'b1;
			end
		end
	end
endmodule : sirr_host_model

// file: sim/status_info_read_responder_test.sv
// Self-checking testbench of the status and information read responder.
`timescale 1ns/1ns
module status_info_read_responder_test;
	logic                  mclk, reset, reg_wr, reg_rd, start, poke, busy, done;
	logic                  rx_full, pf_lvl, fd_lvl, order_bad, query_valid, avail;
	logic [4:0]            reg_addr, n_got;
	logic [31:0]           reg_wdata, reg_rdata, rv;
	logic [7:0]            op;
	logic [7:0]            got [0:14];
	logic [7:0]            e [0:14];
	logic [31:0]           sh [0:16];
	logic [7:0]            ops [0:5] = '{8'hb6, 8'hb8, 8'hba, 8'hbb, 8'hc0, 8'h3c};
	logic [7:0]            rc [0:5] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h07, 8'h08};
	logic [1:0]            r;
	sirr_pkg::sirr_query_t query;
	sirr_pkg::sirr_byte_t  resp;
	int                    n_mismatch = 0;
	int                    checked = 0;
	int                    cyc = 0;

	sirr_top dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .query(query),
		.query_valid(query_valid), .rx_buffer_full(rx_full), .prefetch_pulse_lvl(pf_lvl),
		.fetch_done_lvl(fd_lvl), .resp(resp), .busy(busy));
	sirr_host_model host (.mclk(mclk), .reset(reset), .start(start), .poke(poke), .op(op),
		.resp(resp), .busy(busy), .query(query), .query_valid(query_valid), .got(got),
		.n_got(n_got), .order_bad(order_bad), .done(done));

	// ==========================================================================
	// Clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	// ==========================================================================
	// Shared tasks
	task automatic chk(string what, logic [31:0] exp, logic [31:0] seen);
		checked++;
		if (exp !== seen) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(logic [4:0] a, logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		if (a < 5'h11) sh[a] = d;
	endtask : wr

	task automatic rd(logic [4:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	// Works out the expected answer bytes and returns the answer length.
	function automatic logic [3:0] build(logic [7:0] o);
		logic [1:0] t;
		for (int i = 0; i < 15; i++) e[i] = 8'h00;
		t = (sh[0] > 32'h3) ? 2'h3 : sh[0][1:0];
		case (o)
			sirr_pkg::OP_SOURCE: begin
				e[0] = {6'h00, t};
				if (t != 2'h3) {e[2], e[1]} = sh[1][15:0];
				if (t == 2'h0) begin
					e[3] = sh[2][0] ? 8'h40 : 8'h00;
					e[4] = {4'h0, sh[3][3:0]};
					{e[6], e[5]} = sh[4][15:0];
					for (int i = 0; i < 4; i++) {e[8+2*i], e[7+2*i]} = sh[5+i][15:0];
				end
				if (t == 2'h1) e[3] = {4'h0, sh[9][3:0]};
				if (t == 2'h1) e[4] = {sh[9][7:4], sh[9][11:8]};
				if (t == 2'h2) e[3] = {5'h00, sh[10][2:0]};
				return sirr_pkg::LEN_SOURCE;
			end
			sirr_pkg::OP_DISPLAY: begin
				e[0] = {7'h00, sh[11][2]};
				e[1] = {6'h00, sh[11][1:0]};
				for (int i = 0; i < 4; i++) e[8+i] = sh[12][8*i +: 8];
				return sirr_pkg::LEN_DISPLAY;
			end
			sirr_pkg::OP_SYSINFO: begin
				{e[1], e[0]} = sh[13][15:0];
				return sirr_pkg::LEN_SYSINFO;
			end
			sirr_pkg::OP_FLASH: begin
				e[0] = {3'h0, sh[14][4:0]};
				{e[2], e[1]} = sh[14][23:8];
				return sirr_pkg::LEN_FLASH;
			end
			default: begin
				e[0] = {sh[15][7:5], 1'b0, avail, rx_full, sh[15][1:0]};
				e[1] = sh[15][15:8];
				{e[3], e[2]} = {3'h0, sh[16][12:0]};
				return sirr_pkg::LEN_SHORT;
			end
		endcase
	endfunction : build

	// A rude ask pokes a second query into a running stream, which must be ignored.
	task automatic ask(logic [7:0] o, logic rude);
		logic [3:0] len;
		len = build(o);
		@(posedge mclk);
		op <= o;
		start <= 1'b1;
		@(posedge mclk);
		start <= 1'b0;
		if (rude) begin
			repeat (5) @(posedge mclk);
			poke <= 1'b1;
			@(posedge mclk);
			poke <= 1'b0;
		end
		for (int i = 0; i < 60 && done !== 1'b1; i++) @(posedge mclk);
		repeat (20) @(posedge mclk);
		chk("count", 32'(len), 32'(n_got));
		chk("busy", 32'h0, 32'(busy));
		chk("order", 32'h0, 32'(order_bad));
		for (int i = 0; i < 32'(len); i++) chk("byte", 32'(e[i]), 32'(got[i]));
	endtask : ask

	task automatic wrap_up();
		if (n_mismatch == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up

	// ==========================================================================
	// Main sequence
	initial begin
		reset = 1'b1;
		{reg_wr, reg_rd, start, poke, rx_full, pf_lvl, fd_lvl, avail} = 8'h00;
		reg_addr = 5'h00;
		reg_wdata = 32'h0;
		op = 8'h00;
		for (int i = 0; i < 17; i++) sh[i] = 32'h0;
		void'($urandom(32'hf8f38929));
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		wr(5'h15, 32'hffffffff);
		rd(5'h15, rv);
		chk("unmapped", 32'h0, rv);
		rd(5'h1f, rv);
		chk("unmapped", 32'h0, rv);
		for (int k = 0; k < 48; k++) begin
			r = 2'($urandom_range(3));
			@(posedge mclk);
			rx_full <= r[0];
			if (r[1]) pf_lvl <= ~pf_lvl;
			else fd_lvl <= ~fd_lvl;
			avail = r[1];
			for (int a = 0; a < 17; a++) wr(5'(a), $urandom());
			wr(sirr_pkg::REG_SRC_TYPE, 32'(k % 5));
			wr(sirr_pkg::REG_PATTERN, {20'h0, 4'($urandom_range(7)), 4'($urandom_range(7)),
				4'($urandom_range(8))});
			wr(sirr_pkg::REG_SYSINFO, {24'h0, 8'(k / 6 % 2)} << 8 | 32'(rc[k / 6 % 6]));
			wr(sirr_pkg::REG_STATUS, {16'h0, 8'($urandom_range(255)), 2'(k / 6 % 3),
				6'($urandom())});
			rd(sirr_pkg::REG_FLASH, rv);
			chk("flash readback", {8'h0, sh[14][23:8], 3'h0, sh[14][4:0]}, rv);
			rd(sirr_pkg::REG_PATTERN, rv);
			chk("pattern readback", {20'h0, sh[9][11:0]}, rv);
			ask(ops[k % 6], (k % 6 == 0) && (k % 2 == 0));
		end
		wrap_up();
	end
endmodule : status_info_read_responder_test
